/* File: dpss_defines.vh */
// Constants for the deserializer pin strap and status block
`ifndef DPSS_DEFINES_VH
`define DPSS_DEFINES_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DPSS_DW            14
`define DPSS_ADDR_W        4
`define DPSS_ERRCNT_W      8

// ----------------------------------------------------------------
// Data pin positions
// ----------------------------------------------------------------
`define DPSS_BIT_FSYNC     13
`define DPSS_BIT_LSYNC     12
`define DPSS_BIT_DE        11
`define DPSS_BIT_CABLE     11
`define DPSS_BIT_PROTO     10
`define DPSS_BIT_ADDR_HI   9
`define DPSS_BIT_ADDR_LO   6

// ----------------------------------------------------------------
// States of the strap sequencer
// ----------------------------------------------------------------
`define DPSS_ST_W          2
`define DPSS_ST_DOWN       2'h0
`define DPSS_ST_SAMPLE     2'h1
`define DPSS_ST_RUN        2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DPSS_RST_DATA      14'h0000
`define DPSS_RST_ADDR      4'h0
`define DPSS_RST_ERRCNT    8'h00

`endif

/* File: dpss_pin_strap_status.v */
// Pin strap capture, output pin muxing and status outputs of the deserializer
`timescale 1ns/1ns
`default_nettype none
`include "dpss_defines.vh"

// ----------------------------------------------------------------
// How it works
// [RL1] Pin 13 carries data, or frame sync with sync encoding or wide mode.
// [RL2] Pin 12 carries data, or line sync with sync encoding or wide mode.
// [RL3] Pin 11 carries data enable whenever wide bandwidth mode is one.
// [RL4] Cable strap sampled at power-up and power-down exit; high is coax.
// [RL5] Protocol strap sampled likewise; high is I2C, low is UART.
// [RL6] Four address strap bits captured likewise, then pins drive data.
// [RL7] Cable strap high selects single-ended coax on noninverting inputs.
// [RL8] Line fault low on either monitor fault; high during power-down.
// [RL9] General input is sampled and sent across the link.
// [RL10] Data pin: UART receive input, or open-drain SDA in I2C mode.
// [RL11] Clock pin: UART transmit output, or open-drain SCL in I2C mode.
// [RL12] Error low when error count exceeds threshold or test error seen.
// [RL13] Error held high while power-down input is low.
// [RL14] Lock high only with PLLs locked and word alignment correct.
// [RL15] Lock low while the configuration link is active.
// [RL16] Lock released high while power-down input is low.
// [RL17] Power-down input low puts the block into power-down.
// [RL18] Mode select low is base mode, high is bypass mode.
// [RL19] Wide mode carries eleven video bits, two syncs and data enable per clock.
// [RL20] Control channel pins pass bits at any rate the core uses.
// [RL21] Wide mode turns sync encoding on by default.
// [RL22] Latched straps hold until the next power-up or power-down exit.
// ----------------------------------------------------------------
module dpss_pin_strap_status (
    input  wire                       clk,
    input  wire                       arst_n,
    // Mode and power pins
    input  wire                       power_down_n,
    input  wire                       mode_select_strap,
    input  wire                       wide_bandwidth_mode,
    input  wire                       sync_encode_en,
    // Video stream from the decoder
    input  wire                       vid_valid,
    output wire                       vid_ready,
    input  wire [`DPSS_DW-1:0]        vid_data,
    input  wire                       vid_frame_sync,
    input  wire                       vid_line_sync,
    input  wire                       vid_data_enable,
    // Parallel output pins toward the video receiver
    input  wire                       out_ready,
    output wire                       out_valid,
    output reg  [`DPSS_DW-1:0]        par_out_q,
    output wire [`DPSS_DW-1:0]        par_out_oe,
    input  wire [`DPSS_DW-1:0]        par_pin_in,
    // Captured straps, coax selects and mode status
    output reg                        cable_type_strap_q,
    output reg                        ctrl_protocol_strap_q,
    output reg  [`DPSS_ADDR_W-1:0]    dev_id_strap_q,
    output reg                        straps_valid_q,
    output wire                       coax_in1_single_ended,
    output wire                       coax_in0_single_ended,
    output wire                       bypass_mode,
    output wire                       power_down_active,
    output wire                       sync_encode_active,
    // Line fault
    input  wire                       line_monitor_in0,
    input  wire                       line_monitor_in1,
    output reg                        line_fault_n,
    // General input mirrored at the far end
    input  wire                       general_input_pin,
    output reg                        remote_general_output,
    // Control channel pins
    input  wire                       rx_sda_in,
    output wire                       rx_sda_out,
    output wire                       rx_sda_oe,
    input  wire                       tx_scl_in,
    output wire                       tx_scl_out,
    output wire                       tx_scl_oe,
    output wire                       cc_rx_bit,
    input  wire                       cc_tx_bit,
    input  wire                       cc_sda_drive_low,
    input  wire                       cc_scl_drive_low,
    output wire                       cc_sda_bit,
    output wire                       cc_scl_bit,
    // Error, lock
    input  wire                       decode_err_pulse,
    input  wire                       err_count_clear,
    input  wire [`DPSS_ERRCNT_W-1:0]  err_threshold,
    input  wire                       prbs_test_active,
    input  wire                       prbs_err_pulse,
    input  wire                       pll_locked,
    input  wire                       word_aligned,
    input  wire                       config_link_active,
    output wire                       error_n_out,
    output wire                       error_n_oe,
    output wire                       lock_out,
    output wire                       lock_oe
);

// ----------------------------------------------------------------
// Strap sequencer
// ----------------------------------------------------------------
// Pins float as inputs for two cycles after power-up or power-down
// exit, so the pulldowns settle before the straps are sampled.
reg [`DPSS_ST_W-1:0] state_q;
reg [`DPSS_ST_W-1:0] state_d;
wire                 pins_released;

localparam [`DPSS_ST_W-1:0] ST_DOWN   = `DPSS_ST_DOWN;
localparam [`DPSS_ST_W-1:0] ST_SAMPLE = `DPSS_ST_SAMPLE;
localparam [`DPSS_ST_W-1:0] ST_RUN    = `DPSS_ST_RUN;

always @* begin
    state_d = state_q;
    case (state_q)
        ST_DOWN:   state_d = ST_SAMPLE;
        ST_SAMPLE: state_d = ST_RUN;
        ST_RUN:    state_d = ST_RUN;
        default:   state_d = ST_DOWN;
    endcase
    if (!power_down_n) begin
        state_d = ST_DOWN; // RL17
    end
end

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        state_q <= ST_DOWN;
    end else begin
        state_q <= state_d;
    end
end

assign pins_released     = (state_q == ST_RUN);
assign power_down_active = !power_down_n; // RL17
assign bypass_mode       = mode_select_strap; // RL18

// ----------------------------------------------------------------
// Strap capture
// ----------------------------------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        cable_type_strap_q    <= 1'b0;
        ctrl_protocol_strap_q <= 1'b0;
        dev_id_strap_q        <= `DPSS_RST_ADDR;
        straps_valid_q        <= 1'b0;
    end else if (state_q == ST_SAMPLE && power_down_n) begin
        // Only this state loads them; later pin traffic cannot leak in
        cable_type_strap_q    <= par_pin_in[`DPSS_BIT_CABLE]; // RL4 RL22
        ctrl_protocol_strap_q <= par_pin_in[`DPSS_BIT_PROTO]; // RL5 RL22
        dev_id_strap_q        <=
            par_pin_in[`DPSS_BIT_ADDR_HI:`DPSS_BIT_ADDR_LO]; // RL6 RL22
        straps_valid_q        <= 1'b1;
    end else if (!power_down_n) begin
        straps_valid_q        <= 1'b0;
    end
end

assign coax_in1_single_ended = cable_type_strap_q; // RL7
assign coax_in0_single_ended = cable_type_strap_q; // RL7

// ----------------------------------------------------------------
// Two-entry skid buffer in the video path
// ----------------------------------------------------------------
wire                 sync_mode;
wire [`DPSS_DW-1:0]  mux_word;
reg  [`DPSS_DW-1:0]  buf_q [0:1];
reg                  wr_ptr_q;
reg                  rd_ptr_q;
reg  [1:0]           count_q;
wire                 push;
wire                 pop;

assign sync_encode_active = sync_encode_en | wide_bandwidth_mode; // RL21
assign sync_mode          = sync_encode_active; // RL1 RL2

// Pin-level word; wide mode leaves eleven video bits plus syncs and data enable
genvar gi;
generate
    for (gi = 0; gi < `DPSS_DW; gi = gi + 1) begin : g_mux
        if (gi == `DPSS_BIT_FSYNC) begin : g_fs
            assign mux_word[gi] = sync_mode ? vid_frame_sync
                                            : vid_data[gi]; // RL1 RL19
        end else if (gi == `DPSS_BIT_LSYNC) begin : g_ls
            assign mux_word[gi] = sync_mode ? vid_line_sync
                                            : vid_data[gi]; // RL2 RL19
        end else if (gi == `DPSS_BIT_DE) begin : g_de
            assign mux_word[gi] = wide_bandwidth_mode ? vid_data_enable
                                                      : vid_data[gi]; // RL3
        end else begin : g_plain
            assign mux_word[gi] = vid_data[gi];
        end
    end
endgenerate

assign vid_ready = pins_released && (count_q != 2'h2);
assign out_valid = pins_released && (count_q != 2'h0);
assign push      = vid_valid && vid_ready;
assign pop       = out_valid && out_ready;

always @(posedge clk) begin
    if (push) begin
        buf_q[wr_ptr_q] <= mux_word;
    end
end

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        wr_ptr_q  <= 1'b0;
        rd_ptr_q  <= 1'b0;
        count_q   <= 2'h0;
        par_out_q <= `DPSS_RST_DATA;
    end else if (!pins_released) begin
        // Stale words are dropped across a power-down
        wr_ptr_q  <= 1'b0;
        rd_ptr_q  <= 1'b0;
        count_q   <= 2'h0;
        par_out_q <= `DPSS_RST_DATA;
    end else begin
        if (push) begin
            wr_ptr_q <= ~wr_ptr_q;
        end
        if (pop) begin
            rd_ptr_q  <= ~rd_ptr_q;
            par_out_q <= buf_q[rd_ptr_q];
        end
        if (push && !pop) begin
            count_q <= count_q + 2'h1;
        end else if (pop && !push) begin
            count_q <= count_q - 2'h1;
        end
    end
end

// Pins are inputs until straps are taken, then drive data
assign par_out_oe = {`DPSS_DW{pins_released}}; // RL6

// ----------------------------------------------------------------
// Line fault and general input
// ----------------------------------------------------------------
reg fault_q;

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        fault_q               <= 1'b0;
        remote_general_output <= 1'b0;
    end else begin
        fault_q <= line_monitor_in0 || line_monitor_in1; // RL8
        remote_general_output <= general_input_pin; // RL9
    end
end

// Power-down gate is combinational so the pin goes high at once
always @* begin
    line_fault_n = !power_down_n || !fault_q; // RL8
end

// ----------------------------------------------------------------
// Control channel pins
// ----------------------------------------------------------------
// Both pins are open-drain: only ever pulled low, never driven high
assign rx_sda_out = 1'b0;
assign tx_scl_out = 1'b0;
assign rx_sda_oe  = ctrl_protocol_strap_q && cc_sda_drive_low; // RL10
assign tx_scl_oe  = ctrl_protocol_strap_q ? cc_scl_drive_low
                                          : !cc_tx_bit; // RL11 RL20
assign cc_rx_bit  = ctrl_protocol_strap_q ? 1'b1 : rx_sda_in; // RL10 RL20
assign cc_sda_bit = ctrl_protocol_strap_q ? rx_sda_in : 1'b1; // RL10
assign cc_scl_bit = ctrl_protocol_strap_q ? tx_scl_in : 1'b1; // RL11

// ----------------------------------------------------------------
// Error and lock
// ----------------------------------------------------------------
reg [`DPSS_ERRCNT_W-1:0] err_cnt_q;
reg                      prbs_seen_q;
reg                      err_flag_q;
reg                      lock_q;

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        err_cnt_q   <= `DPSS_RST_ERRCNT;
        prbs_seen_q <= 1'b0;
    end else if (!power_down_n) begin
        err_cnt_q   <= `DPSS_RST_ERRCNT;
        prbs_seen_q <= 1'b0;
    end else begin
        // A new error in the clearing cycle still counts
        if (decode_err_pulse && !prbs_test_active) begin
            if (err_count_clear) begin
                err_cnt_q <= {{(`DPSS_ERRCNT_W-1){1'b0}}, 1'b1};
            end else if (err_cnt_q != {`DPSS_ERRCNT_W{1'b1}}) begin
                err_cnt_q <= err_cnt_q + {{(`DPSS_ERRCNT_W-1){1'b0}}, 1'b1};
            end
        end else if (err_count_clear) begin
            err_cnt_q <= `DPSS_RST_ERRCNT;
        end
        if (prbs_test_active && prbs_err_pulse) begin
            prbs_seen_q <= 1'b1;
        end else if (err_count_clear || !prbs_test_active) begin
            prbs_seen_q <= 1'b0;
        end
    end
end

always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        err_flag_q <= 1'b0;
        lock_q     <= 1'b0;
    end else begin
        err_flag_q <= power_down_n &&
            ((!prbs_test_active && err_cnt_q > err_threshold) ||
             prbs_seen_q); // RL12 RL13
        lock_q <= pll_locked && word_aligned &&
            !config_link_active; // RL14 RL15
    end
end

assign error_n_out = 1'b0;
// Released at once in power-down, not one edge later
assign error_n_oe  = power_down_n && err_flag_q; // RL12 RL13
// Lock pin is open-drain; released (high) in power-down
assign lock_out    = 1'b0;
assign lock_oe     = power_down_n && !lock_q; // RL14 RL16

endmodule // dpss_pin_strap_status
`default_nettype wire

/* File: dpss_checker.sv */
// Concurrent checks on the pin strap and status block ports
`timescale 1ns/1ns
`default_nettype none
module dpss_checker (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        power_down_n,
    input wire logic        line_monitor_in0,
    input wire logic        line_monitor_in1,
    input wire logic        line_fault_n,
    input wire logic        error_n_oe,
    input wire logic        lock_oe,
    input wire logic        pll_locked,
    input wire logic        word_aligned,
    input wire logic        config_link_active,
    input wire logic        straps_valid_q,
    input wire logic        cable_type_strap_q,
    input wire logic        ctrl_protocol_strap_q,
    input wire logic [3:0]  dev_id_strap_q,
    input wire logic [13:0] par_out_oe,
    input wire logic [13:0] par_pin_in,
    input wire logic        vid_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // Strap capture and hold
    // ------------------------------------------------------------
    sequence s_wake;
        !power_down_n ##1 power_down_n [*2];
    endsequence
    // Four awake edges put the load edge safely in the past
    sequence s_awake;
        power_down_n [*4];
    endsequence
    a_strap_take: assert property (s_wake |=> straps_valid_q
        && cable_type_strap_q == $past(par_pin_in[11])
        && ctrl_protocol_strap_q == $past(par_pin_in[10])
        && dev_id_strap_q == $past(par_pin_in[9:6]))
        else $error("strap capture wrong");
    a_strap_hold: assert property (s_awake ##0 $past(straps_valid_q)
        |-> $stable({cable_type_strap_q, ctrl_protocol_strap_q,
                     dev_id_strap_q}))
        else $error("strap changed while awake");
    a_pins_out: assert property (power_down_n && straps_valid_q
        |-> par_out_oe == 14'h3FFF)
        else $error("data pins not driven");
    a_ready_held: assert property (!straps_valid_q |-> !vid_ready)
        else $error("stream taken before release");
    // ------------------------------------------------------------
    // Status pins
    // ------------------------------------------------------------
    a_fault_pd: assert property (!power_down_n |-> line_fault_n)
        else $error("line fault low in power-down");
    a_fault_follow: assert property (power_down_n ##1 power_down_n
        |-> line_fault_n == !$past(line_monitor_in0 || line_monitor_in1))
        else $error("line fault wrong");
    a_err_pd: assert property (!power_down_n |-> !error_n_oe)
        else $error("error pin low in power-down");
    a_lock_pd: assert property (!power_down_n |-> !lock_oe)
        else $error("lock pin low in power-down");
    a_lock_good: assert property ((power_down_n &&
        !config_link_active) ##1 power_down_n
        |-> lock_oe == !$past(pll_locked && word_aligned))
        else $error("lock does not follow pll and alignment");
    a_lock_cfg: assert property ((power_down_n &&
        config_link_active) ##1 power_down_n |-> lock_oe)
        else $error("lock high with config link");
endmodule // dpss_checker
bind dpss_pin_strap_status dpss_checker u_chk (.*);
`default_nettype wire

/* File: dpss_sink.sv */
// Downstream video receiver model that can stall the output stream
`timescale 1ns/1ns
`default_nettype none
module dpss_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic stall,
    input wire logic out_valid,
    output var logic out_ready,
    output var logic got
);
    // Ready moves only after an edge; got marks a fresh word on the pins
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_ready <= 1'h0;
            got <= 1'h0;
        end else begin
            out_ready <= !stall;
            got <= out_valid && out_ready;
        end
    end
endmodule // dpss_sink
`default_nettype wire

/* File: dpss_pin_strap_status_tb_top.sv */
// Self-checking bench of the pin strap and status block
`timescale 1ns/1ns
`default_nettype none
module dpss_pin_strap_status_tb_top;
    logic clk, arst_n, power_down_n, mode_select_strap, wide_bandwidth_mode;
    logic sync_encode_en, vid_valid, vid_frame_sync, vid_line_sync;
    logic vid_data_enable, line_monitor_in0, line_monitor_in1;
    logic general_input_pin, cc_tx_bit, cc_sda_drive_low, cc_scl_drive_low;
    logic decode_err_pulse, err_count_clear, prbs_test_active, prbs_err_pulse;
    logic pll_locked, word_aligned, config_link_active, stall, sda_drv, scl_drv;
    logic [13:0] vid_data, strap_lvl, e;
    logic [7:0]  err_threshold;
    wire out_ready, got, vid_ready, out_valid, cable_type_strap_q, bypass_mode;
    wire ctrl_protocol_strap_q, straps_valid_q, coax_in1_single_ended;
    wire coax_in0_single_ended, power_down_active, sync_encode_active;
    wire line_fault_n, remote_general_output, rx_sda_out, rx_sda_oe, rx_sda_in;
    wire tx_scl_out, tx_scl_oe, tx_scl_in, cc_rx_bit, cc_sda_bit, cc_scl_bit;
    wire error_n_out, error_n_oe, lock_out, lock_oe;
    wire [13:0] par_out_q, par_out_oe, par_pin_in;
    wire [3:0]  dev_id_strap_q;
    int n_fail = 0, num_checks = 0, cyc = 0;
    // Strap resistors win only while the block leaves the pins alone
    assign par_pin_in = (par_out_oe & par_out_q) | (~par_out_oe & strap_lvl);
    assign rx_sda_in = sda_drv & !rx_sda_oe;
    assign tx_scl_in = scl_drv & !tx_scl_oe;
    dpss_pin_strap_status u_dut (.*);
    dpss_sink u_sink (.*);
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(string nm, logic [13:0] exp, logic [13:0] seen);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic push(logic [13:0] d);
        vid_valid = 1'h1;
        vid_data = d;
        for (int i = 0; i < 50 && vid_ready !== 1'h1; i++) tick();
        tick();
        vid_valid = 1'h0;
        tick();
    endtask
    task automatic rx(logic [13:0] exp);
        for (int i = 0; i < 50 && got !== 1'h1; i++) tick();
        chk("par_out", exp, par_out_q);
        tick();
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {arst_n, mode_select_strap, wide_bandwidth_mode, sync_encode_en,
         vid_valid, vid_frame_sync, vid_line_sync, vid_data_enable, stall,
         line_monitor_in0, line_monitor_in1, general_input_pin, pll_locked,
         cc_sda_drive_low, cc_scl_drive_low, decode_err_pulse, word_aligned,
         err_count_clear, prbs_test_active, prbs_err_pulse,
         config_link_active, vid_data} = '0;
        {power_down_n, sda_drv, scl_drv, cc_tx_bit} = 4'hF;
        strap_lvl = 14'h0A80;
        err_threshold = 8'h02;
        tick(8);
        arst_n = 1'h1;
        tick(4);
        chk("cable", 1'h1, cable_type_strap_q);
        chk("proto", 1'h0, ctrl_protocol_strap_q);
        chk("dev_id", 4'hA, dev_id_strap_q);
        chk("coax", 1'h1, coax_in0_single_ended & coax_in1_single_ended);
        chk("valid", 1'h1, straps_valid_q);
        {sda_drv, cc_tx_bit} = 2'h0;
        tick(2);
        chk("uart_rx", 1'h0, cc_rx_bit);
        chk("uart_tx", 1'h1, tx_scl_oe);
        chk("uart_sda", 1'h1, cc_sda_bit);
        chk("od_low", 4'h0, {rx_sda_out, tx_scl_out, error_n_out, lock_out});
        {sda_drv, cc_tx_bit, vid_frame_sync, vid_data_enable} = 4'hF;
        for (int m = 0; m < 4; m++) begin
            {wide_bandwidth_mode, sync_encode_en} = 2'(m);
            e = 14'h1555;
            if (m != 0) e[13:12] = 2'h2;
            if (m > 1) e[11] = 1'h1;
            tick();
            chk("sync_on", 1'(m != 0), sync_encode_active);
            push(14'h1555);
            rx(e);
        end
        {wide_bandwidth_mode, sync_encode_en} = 2'h0;
        stall = 1'h1;
        tick();
        push(14'h0001);
        push(14'h0002);
        vid_valid = 1'h1;
        tick(3);
        chk("full", 1'h0, vid_ready);
        stall = 1'h0;
        fork
            push(14'h0003);
            begin
                rx(14'h0001);
                rx(14'h0002);
                rx(14'h0003);
            end
        join
        chk("dev_hold", 4'hA, dev_id_strap_q);
        line_monitor_in0 = 1'h1;
        tick(2);
        chk("fault0", 1'h0, line_fault_n);
        {line_monitor_in0, line_monitor_in1} = 2'h1;
        {general_input_pin, pll_locked, word_aligned} = 3'h7;
        tick(2);
        chk("fault1", 1'h0, line_fault_n);
        chk("gpo", 1'h1, remote_general_output);
        chk("lock", 1'h0, lock_oe);
        config_link_active = 1'h1;
        tick(2);
        chk("lock_cfg", 1'h1, lock_oe);
        {config_link_active, word_aligned, mode_select_strap} = 3'h1;
        tick(2);
        chk("lock_align", 1'h1, lock_oe);
        chk("bypass", 1'h1, bypass_mode);
        for (int k = 1; k <= 3; k++) begin
            decode_err_pulse = 1'h1;
            tick();
            decode_err_pulse = 1'h0;
            tick();
            chk("err_cnt", 1'(k > 2), error_n_oe);
        end
        err_count_clear = 1'h1;
        tick();
        err_count_clear = 1'h0;
        tick(2);
        chk("err_clr", 1'h0, error_n_oe);
        {prbs_test_active, prbs_err_pulse} = 2'h3;
        tick();
        prbs_err_pulse = 1'h0;
        tick(2);
        chk("err_prbs", 1'h1, error_n_oe);
        strap_lvl = 14'h0640;
        power_down_n = 1'h0;
        tick(2);
        chk("pd_fault", 1'h1, line_fault_n);
        chk("pd_err", 1'h0, error_n_oe);
        chk("pd_lock", 1'h0, lock_oe);
        chk("pd_act", 1'h1, power_down_active);
        power_down_n = 1'h1;
        tick(4);
        chk("cable2", 1'h0, cable_type_strap_q);
        chk("proto2", 1'h1, ctrl_protocol_strap_q);
        chk("dev_id2", 4'h9, dev_id_strap_q);
        {cc_sda_drive_low, cc_scl_drive_low} = 2'h3;
        tick();
        chk("sda_oe", 1'h1, rx_sda_oe);
        chk("scl_oe", 1'h1, tx_scl_oe);
        chk("i2c_rx", 1'h1, cc_rx_bit);
        {cc_sda_drive_low, cc_scl_drive_low, scl_drv, sda_drv} = 4'h0;
        tick();
        chk("scl_in", 1'h0, cc_scl_bit);
        chk("sda_in", 1'h0, cc_sda_bit);
        print_verdict();
    end
endmodule // dpss_pin_strap_status_tb_top
`default_nettype wire
